// ==== hdl/uoec_top.sv ====
// usb out endpoint configuration byte with its buffer-manager update logic
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "uoec_cfg.svh"
module uoec_top #(
  parameter int AW = 4
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [AW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // packet results from the serial engine
  input wire uoec_pkg::uoec_pkt_t pkt_i,
  // handshake answer and buffer choice
  output uoec_pkg::uoec_ans_t ans_o,
  // configuration view and interrupt
  output logic [7:0] cnf_o,
  output logic irq_o
);
  import uoec_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // configuration byte
  logic [7:0] cnf_reg;
  logic [7:0] cnf_next;
  logic buf_y_reg;
  uoec_ans_t ans_reg;
  logic wr_cnf;
  logic wr_stat;
  logic wr_mask;
  logic [7:0] stat_w;
  logic [7:0] mask_w;

  wire active = cnf_reg[`UOEC_BIT_ACTIVE]; // R2
  wire iso = cnf_reg[`UOEC_BIT_ISO];
  wire tog = cnf_reg[`UOEC_BIT_TOGGLE];
  wire dual = cnf_reg[`UOEC_BIT_DUAL];
  wire stall = cnf_reg[`UOEC_BIT_STALL];
  wire irq_allow = cnf_reg[`UOEC_BIT_IRQ_ALLOW]; // R12
  // isochronous layout is handled elsewhere; this block stands aside then
  wire cib_mode = ~iso; // R1 R3 R4
  wire take = pkt_i.valid & active & cib_mode; // R2
  wire is_setup = pkt_i.stage == UOEC_STG_SETUP;
  wire pid_ok = pkt_i.pid_data1 == tog; // R9
  wire good = pkt_i.crc_ok & ~pkt_i.overrun;
  wire overrun_ctl = take & pkt_i.overrun & ~is_setup; // R11
  wire stalled = stall & ~is_setup; // R10
  wire ok_data = take & ~stalled & good & pkt_i.buf_free & pid_ok; // R5 R9
  wire hw_stall = overrun_ctl & ~stall; // R11

  function automatic uoec_hs_t pick_hs(input logic tk, input logic st, input logic ov,
                                       input logic gd, input logic fr);
    if (!tk) return UOEC_HS_NONE;
    else if (st || ov) return UOEC_HS_STALL;
    else if (!gd) return UOEC_HS_NONE;
    else if (!fr) return UOEC_HS_NAK;
    else return UOEC_HS_ACK;
  endfunction

  wire uoec_hs_t hs_w = pick_hs(take, stalled, overrun_ctl, good, pkt_i.buf_free); // R10

  // toggle and stall updates beside firmware writes; hardware wins on a tie
  always_comb begin
    cnf_next = cnf_reg;
    if (wr_cnf) cnf_next = {wdata_i[7:2], 2'b00};
    if (ok_data) cnf_next[`UOEC_BIT_TOGGLE] = ~tog; // R5
    if (overrun_ctl) cnf_next[`UOEC_BIT_STALL] = 1'b1; // R11
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) cnf_reg <= `UOEC_RST_CNF;
    else cnf_reg <= cnf_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffer selection
  // a mismatched pid is acked but not stored, so the buffer does not advance
  wire store = ok_data;
  wire use_y = dual & buf_y_reg; // R6 R8
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) buf_y_reg <= 1'b0;
    else if (!dual) buf_y_reg <= 1'b0; // R8
    else if (store) buf_y_reg <= ~buf_y_reg; // R6
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) ans_reg <= '{valid: 1'b0, hs: UOEC_HS_NONE, store: 1'b0, use_y: 1'b0};
    else ans_reg <= '{valid: take, hs: hs_w, store: store, use_y: use_y};
  end
  assign ans_o = ans_reg;
  assign cnf_o = cnf_reg;

  ////////////////////////////////////////////////////////////////////////////
  // software port and interrupt
  uoec_regbank #(.AW(AW)) u_regs (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .wr_cnf_o(wr_cnf),
    .wr_stat_o(wr_stat),
    .wr_mask_o(wr_mask),
    .cnf_i(cnf_reg),
    .stat_i(stat_w),
    .mask_i(mask_w)
  );

  // events reach the status only while the endpoint allows its interrupt
  wire [2:0] ev_w = {take & ~pid_ok & good & ~stalled,
                     hw_stall,
                     ok_data} & {3{irq_allow}}; // R12 R11

  uoec_irq #(.NEV(3)) u_irq (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .ev_i(ev_w),
    .wr_stat_i(wr_stat),
    .wr_mask_i(wr_mask),
    .wdata_i(wdata_i),
    .stat_o(stat_w),
    .mask_o(mask_w),
    .irq_o(irq_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  AST_TOGGLE_FLIP: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R5
    ok_data && !wr_cnf |=> cnf_reg[`UOEC_BIT_TOGGLE] != $past(tog))
    else $error("toggle did not invert after good packet");
  AST_TOGGLE_HOLD: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R9
    take && !pid_ok && !wr_cnf |=> cnf_reg[`UOEC_BIT_TOGGLE] == $past(tog))
    else $error("toggle changed on pid mismatch");
  AST_SINGLE_X: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R8
    !dual |=> !ans_o.use_y)
    else $error("y buffer used in single mode");
  AST_DUAL_ALT: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R6
    store && dual ##1 dual |-> buf_y_reg != $past(buf_y_reg))
    else $error("buffers did not alternate");
  AST_STALL_ANS: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R10
    take && stall && !is_setup |=> ans_o.hs == UOEC_HS_STALL)
    else $error("stalled endpoint not answering stall");
  AST_SETUP_PASS: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R10
    take && is_setup && good && pkt_i.buf_free |=> ans_o.hs == UOEC_HS_ACK)
    else $error("setup stage refused");
  AST_HW_STALL: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R11
    overrun_ctl |=> cnf_reg[`UOEC_BIT_STALL])
    else $error("overrun did not set stall");
  AST_INACTIVE: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R2
    pkt_i.valid && (!active || iso) |=> !ans_o.valid && !ans_o.store)
    else $error("inactive endpoint answered");
  AST_IRQ: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R11
    hw_stall && irq_allow && mask_w[`UOEC_EV_STALL] && !wr_mask |=> irq_o)
    else $error("overrun interrupt missing");

  // reset state; the reset is synchronous, so these run without the disable
  AST_RST_CNF: assert property (@(posedge clock_i) // R2
    !rst_b_i |=> cnf_reg == `UOEC_RST_CNF && !buf_y_reg)
    else $error("configuration not cleared by reset");
  AST_RST_ANS: assert property (@(posedge clock_i) // R2
    !rst_b_i |=> !ans_o.valid && !ans_o.store && ans_o.hs == UOEC_HS_NONE)
    else $error("answer not idle after reset");
  AST_RST_IRQ: assert property (@(posedge clock_i) // R12
    !rst_b_i |=>
    stat_w == `UOEC_RST_STAT && mask_w == `UOEC_RST_MASK && !irq_o)
    else $error("status, mask or interrupt not cleared by reset");

  // firmware-owned fields move only on a firmware write
  AST_SW_ACTIVE: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R2
    !wr_cnf |=> active == $past(active))
    else $error("enable bit changed without a write");
  AST_SW_ISO: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R1
    !wr_cnf |=> iso == $past(iso))
    else $error("type bit changed without a write");
  AST_SW_DUAL: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R6
    !wr_cnf |=> dual == $past(dual))
    else $error("double-buffer bit changed without a write");
  AST_SW_ALLOW: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R12
    !wr_cnf |=> irq_allow == $past(irq_allow))
    else $error("interrupt-allow bit changed without a write");
  AST_RESV_ZERO: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R1
    cnf_reg[1:0] == 2'b00)
    else $error("reserved bits not zero");
  AST_WR_CNF: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R2
    wr_cnf && !take |=> cnf_reg[7:2] == $past(wdata_i[7:2]))
    else $error("configuration write not taken");
  AST_HOLD: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R5
    !wr_cnf && !take |=> cnf_reg == $past(cnf_reg))
    else $error("configuration changed while idle");
  AST_ISO_HOLD: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R1
    iso && !wr_cnf |=> cnf_reg == $past(cnf_reg))
    else $error("hardware touched an isochronous configuration");

  // toggle moves only on a good packet or a firmware write
  AST_TOG_ONLY_GOOD: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R5
    !ok_data && !wr_cnf |=> tog == $past(tog))
    else $error("toggle changed without a good packet");
  AST_TOG_STALL: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R10
    take && stalled && !wr_cnf |=> tog == $past(tog))
    else $error("toggle changed on a stalled packet");
  AST_TOG_NAK: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R5
    take && !pkt_i.buf_free && !wr_cnf |=> tog == $past(tog))
    else $error("toggle changed on a refused packet");

  // handshake answer
  AST_ANS_VALID: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R2
    take |=> ans_o.valid)
    else $error("taken packet not answered");
  AST_ANS_IDLE: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R2
    !take |=>
    !ans_o.valid && !ans_o.store && ans_o.hs == UOEC_HS_NONE)
    else $error("answer without a taken packet");
  AST_ISO_NONE: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R1
    iso |=> ans_o.hs == UOEC_HS_NONE)
    else $error("handshake given in isochronous layout");
  AST_STORE_ACK: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R5
    ans_o.store |-> ans_o.hs == UOEC_HS_ACK && ans_o.valid)
    else $error("packet stored without ack");
  AST_STORE_PID: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R9
    take && !pid_ok |=> !ans_o.store)
    else $error("mismatched pid stored");
  AST_BAD_CRC: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R5
    take && !pkt_i.crc_ok && !stalled && !pkt_i.overrun |=>
    ans_o.hs == UOEC_HS_NONE)
    else $error("damaged packet answered");
  AST_NAK: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R5
    take && !stalled && good && !pkt_i.buf_free |=>
    ans_o.hs == UOEC_HS_NAK)
    else $error("busy buffer not answered with nak");
  AST_STALL_NOSTORE: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R10
    take && stalled |=> !ans_o.store)
    else $error("stalled packet stored");
  AST_SETUP_NOSTALL: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R10
    take && is_setup |=> ans_o.hs != UOEC_HS_STALL)
    else $error("setup stage stalled");
  AST_OVR_ANS: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R11
    overrun_ctl |=> ans_o.hs == UOEC_HS_STALL && !ans_o.store)
    else $error("overrun not answered with stall");

  // stall bit: firmware clears it, hardware only sets it
  AST_STALL_KEEP: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R10
    stall && !wr_cnf |=> cnf_reg[`UOEC_BIT_STALL])
    else $error("stall cleared by hardware");
  AST_STALL_SRC: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R11
    !stall && !overrun_ctl && !wr_cnf |=> !cnf_reg[`UOEC_BIT_STALL])
    else $error("stall set without a cause");

  // buffer choice
  AST_SINGLE_CLR: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R8
    !dual |=> !buf_y_reg)
    else $error("y pointer kept in single mode");
  AST_DUAL_HOLD: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R6
    dual && !store |=> buf_y_reg == $past(buf_y_reg))
    else $error("buffer pointer moved without a store");
  AST_USE_Y_DUAL: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R8
    ans_o.use_y |-> $past(dual))
    else $error("y buffer chosen outside double mode");
  AST_FIRST_X: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R6
    $rose(dual) |-> !buf_y_reg)
    else $error("double mode did not start on x");

  // events and interrupt
  AST_EV_BLOCK: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R12
    !irq_allow && !wr_stat |=> stat_w == $past(stat_w))
    else $error("event recorded while interrupt not allowed");
  AST_EV_DONE: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R12
    ok_data && irq_allow |=> stat_w[`UOEC_EV_DONE])
    else $error("good packet not recorded");
  AST_EV_BADPID: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R9
    take && !pid_ok && good && !stalled && irq_allow |=>
    stat_w[`UOEC_EV_BADPID])
    else $error("pid mismatch not recorded");
  AST_EV_STALL: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R11
    hw_stall && irq_allow |=> stat_w[`UOEC_EV_STALL])
    else $error("hardware stall not recorded");
  AST_IRQ_MASKED: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R12
    mask_w == 8'h00 |-> !irq_o)
    else $error("interrupt with every source masked");
  AST_IRQ_LOW: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R12
    stat_w == 8'h00 |-> !irq_o)
    else $error("interrupt with empty status");
  AST_RD_CNF: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R2
    rd_i && addr_i == AW'(`UOEC_ADDR_CNF) |=>
    rdata_o == $past(cnf_reg))
    else $error("configuration read returned wrong data");

  // per status bit: sticky until a written one, mask moves only on a write
  for (genvar i = 0; i < 3; i++) begin : g_sticky
    AST_STICKY: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R11
      stat_w[i] && !(wr_stat && wdata_i[i]) |=> stat_w[i])
      else $error("status bit lost without a clear");
    AST_MASK_HOLD: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R12
      !wr_mask |=> mask_w[i] == $past(mask_w[i]))
      else $error("mask bit changed without a write");
  end
endmodule
`default_nettype wire

// ==== hdl/uoec_cfg.svh ====
// constants and functional notes for the usb out endpoint configuration byte
// Functional notes
// R1: bit meanings depend on type; this layout applies only while iso bit is clear
// R2: firmware sets bit 7 to activate; endpoint serves host only while set
// R3: firmware writes 1 to bit 6 to make the endpoint isochronous
// R4: firmware keeps bit 6 at 0 for control, interrupt or bulk
// R5: buffer manager inverts toggle bit 5 on a good out data stage
// R6: with bit 4 set, successive packets alternate between x and y buffers
// R7: firmware clears bit 4 to select single-buffer operation
// R8: single-buffer mode places packets only in the x buffer
// R9: expect data0 while toggle is 0, data1 while 1; mismatch keeps toggle
// R10: stall bit 3 answers stall to all but control setup stages
// R11: too much control write data sets stall and raises the interrupt; the code records the stall event only if stall bit 3 was clear
// R12: firmware sets bit 2 to allow this endpoint's interrupt
`ifndef UOEC_CFG_SVH
`define UOEC_CFG_SVH
`define UOEC_ADDR_CNF 4'h0
`define UOEC_ADDR_STAT 4'h1
`define UOEC_ADDR_MASK 4'h2
`define UOEC_BIT_ACTIVE 7
`define UOEC_BIT_ISO 6
`define UOEC_BIT_TOGGLE 5
`define UOEC_BIT_DUAL 4
`define UOEC_BIT_STALL 3
`define UOEC_BIT_IRQ_ALLOW 2
`define UOEC_RST_CNF 8'h00
`define UOEC_RST_STAT 8'h00
`define UOEC_RST_MASK 8'h00
`define UOEC_EV_DONE 0
`define UOEC_EV_STALL 1
`define UOEC_EV_BADPID 2
`endif

// ==== hdl/uoec_pkg.sv ====
// types for the usb out endpoint configuration block
package uoec_pkg;
  typedef enum logic [1:0] {
    UOEC_HS_ACK = 2'h0,
    UOEC_HS_NAK = 2'h1,
    UOEC_HS_STALL = 2'h2,
    UOEC_HS_NONE = 2'h3
  } uoec_hs_t;
  typedef enum logic [1:0] {
    UOEC_STG_SETUP = 2'h0,
    UOEC_STG_DATA = 2'h1,
    UOEC_STG_STATUS = 2'h2
  } uoec_stage_t;
  typedef struct packed {
    logic valid;
    logic crc_ok;
    logic pid_data1;
    logic overrun;
    logic buf_free;
    uoec_stage_t stage;
  } uoec_pkt_t;
  typedef struct packed {
    logic valid;
    uoec_hs_t hs;
    logic store;
    logic use_y;
  } uoec_ans_t;
endpackage

// ==== hdl/uoec_regbank.sv ====
// software register port: address decode and one-cycle read data
`timescale 1ns/100ps
`default_nettype none
`include "uoec_cfg.svh"
module uoec_regbank #(
  parameter int AW = 4
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // bus
  input wire logic [AW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // decoded strobes and read sources
  output logic wr_cnf_o,
  output logic wr_stat_o,
  output logic wr_mask_o,
  input wire logic [7:0] cnf_i,
  input wire logic [7:0] stat_i,
  input wire logic [7:0] mask_i
);
  import uoec_pkg::*;
  logic [7:0] rdata_reg;
  wire sel_cnf = addr_i == AW'(`UOEC_ADDR_CNF);
  wire sel_stat = addr_i == AW'(`UOEC_ADDR_STAT);
  wire sel_mask = addr_i == AW'(`UOEC_ADDR_MASK);
  // unmapped addresses read as zero
  wire [7:0] rd_mux = sel_cnf ? cnf_i : sel_stat ? stat_i : sel_mask ? mask_i : 8'h00;
  assign wr_cnf_o = wr_i & sel_cnf;
  assign wr_stat_o = wr_i & sel_stat;
  assign wr_mask_o = wr_i & sel_mask;
  assign rdata_o = rdata_reg;
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) rdata_reg <= 8'h00;
    else if (rd_i) rdata_reg <= rd_mux;
    else rdata_reg <= 8'h00;
  end
  initial begin
    if (AW < 2) $error("uoec_regbank: address too narrow");
  end
endmodule
`default_nettype wire

// ==== hdl/uoec_irq.sv ====
// sticky event status, write-one-to-clear, masked level interrupt
`timescale 1ns/100ps
`default_nettype none
`include "uoec_cfg.svh"
module uoec_irq #(
  parameter int NEV = 3
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // events and software access
  input wire logic [NEV-1:0] ev_i,
  input wire logic wr_stat_i,
  input wire logic wr_mask_i,
  input wire logic [7:0] wdata_i,
  // state
  output logic [7:0] stat_o,
  output logic [7:0] mask_o,
  output logic irq_o
);
  import uoec_pkg::*;
  logic [NEV-1:0] stat_reg;
  logic [NEV-1:0] mask_reg;
  logic [NEV-1:0] stat_next;
  // set wins over a same-cycle write-one clear
  assign stat_next = (stat_reg & ~(wr_stat_i ? wdata_i[NEV-1:0] : '0)) | ev_i;
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      stat_reg <= NEV'(`UOEC_RST_STAT);
      mask_reg <= NEV'(`UOEC_RST_MASK);
    end else begin
      stat_reg <= stat_next;
      if (wr_mask_i) mask_reg <= wdata_i[NEV-1:0];
    end
  end
  assign stat_o = 8'(stat_reg);
  assign mask_o = 8'(mask_reg);
  assign irq_o = |(stat_reg & mask_reg);
  initial begin
    if (NEV < 1 || NEV > 8) $error("uoec_irq: NEV must be 1..8");
  end
endmodule
`default_nettype wire

// ==== verif/uoec_host.sv ====
// host-side model that delivers out transaction results to the endpoint
`timescale 1ns/100ps
`default_nettype none
module uoec_host (
  // clock
  input wire logic clock_i,
  // packet result out, handshake answer back
  output uoec_pkg::uoec_pkt_t pkt_o,
  input wire uoec_pkg::uoec_ans_t ans_i
);
  import uoec_pkg::*;
  initial pkt_o = 7'h00;
  // one packet per call; the answer is taken in the cycle after the pulse
  task automatic send(input uoec_pkt_t p, output uoec_ans_t a);
    @(posedge clock_i);
    pkt_o <= p;
    @(posedge clock_i);
    // idle fields inverted so a stale packet never looks current
    pkt_o <= {1'b0, ~p[5:0]};
    #1 a = ans_i;
  endtask
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// self-checking bench for the out endpoint configuration block
`timescale 1ns/100ps
`default_nettype none
`include "uoec_cfg.svh"
module testbench;
  import uoec_pkg::*;
  // answer codes: valid, handshake, store, use_y
  localparam logic [4:0] ACK_X = 5'h12;
  localparam logic [4:0] ACK_Y = 5'h13;
  localparam logic [4:0] ACK_N = 5'h10;
  localparam logic [4:0] NAK = 5'h14;
  localparam logic [4:0] STL = 5'h18;
  localparam logic [4:0] ALL = 5'h1f;
  localparam logic [4:0] HS = 5'h1c;
  localparam logic [4:0] VLD = 5'h10;
  localparam logic [4:0] BAD = 5'h1c;
  localparam logic [3:0] CNF = `UOEC_ADDR_CNF;
  localparam logic [3:0] STAT = `UOEC_ADDR_STAT;
  localparam logic [3:0] MASK = `UOEC_ADDR_MASK;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic [7:0] cnf_o;
  logic irq_o;
  uoec_pkt_t pkt_i;
  uoec_ans_t ans_o;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  always #2 clock_i = ~clock_i;
  uoec_top #(.AW(4)) i_uoec_top (.clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pkt_i(pkt_i),
    .ans_o(ans_o), .cnf_o(cnf_o), .irq_o(irq_o));
  uoec_host i_uoec_host (.clock_i(clock_i), .pkt_o(pkt_i), .ans_i(ans_o));
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("counts: %0d checked, %0d mismatches", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [7:0] dt);
    @(posedge clock_i);
    addr_i <= ad;
    wdata_i <= dt;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] ad, input logic [7:0] ex);
    @(posedge clock_i);
    addr_i <= ad;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, ex);
  endtask
  // s stage, p pid is data1, ok crc good, ov overrun, fr buffer free
  task automatic pk(input logic [1:0] s, input logic p, ok, ov, fr,
                    input logic [4:0] ex, input logic [4:0] m);
    uoec_ans_t a;
    i_uoec_host.send({1'b1, ok, p, ov, fr, s}, a);
    chk({3'h0, a & m}, {3'h0, ex});
  endtask
  // hang guard, far above the length of the sequence
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      $display("mismatch at %0t: timeout", $time);
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clock_i);
    rst_b_i <= 1'b1;
    rd(CNF, `UOEC_RST_CNF);
    rd(STAT, `UOEC_RST_STAT);
    rd(MASK, `UOEC_RST_MASK);
    wr(4'h3, 8'hff);
    rd(4'h3, 8'h00);
    pk(2'h1, 0, 1, 0, 1, 5'h00, VLD);
    wr(CNF, 8'hc4);
    pk(2'h1, 0, 1, 0, 1, 5'h00, VLD);
    $display("test reset and inactive done");
    wr(CNF, 8'h87);
    rd(CNF, 8'h84);
    pk(2'h1, 0, 1, 0, 1, ACK_X, ALL);
    rd(CNF, 8'ha4);
    chk(cnf_o, 8'ha4);
    pk(2'h1, 1, 0, 0, 1, BAD, ALL);
    pk(2'h1, 0, 1, 0, 1, ACK_N, ALL);
    rd(CNF, 8'ha4);
    pk(2'h1, 1, 1, 0, 0, NAK, ALL);
    pk(2'h1, 1, 1, 0, 1, ACK_X, ALL);
    rd(CNF, 8'h84);
    rd(STAT, 8'h05);
    $display("test single buffer done");
    wr(CNF, 8'h94);
    pk(2'h1, 0, 1, 0, 1, ACK_X, ALL);
    pk(2'h1, 1, 1, 0, 1, ACK_Y, ALL);
    rd(CNF, 8'h94);
    $display("test dual buffer done");
    wr(CNF, 8'h9c);
    pk(2'h1, 0, 1, 0, 1, STL, HS);
    pk(2'h2, 0, 1, 0, 1, STL, HS);
    pk(2'h0, 0, 1, 0, 1, ACK_N, HS);
    $display("test stall done");
    wr(STAT, 8'h07);
    wr(MASK, 8'h02);
    wr(CNF, 8'h84);
    pk(2'h1, 0, 1, 0, 1, ACK_X, ALL);
    chk({7'h00, irq_o}, 8'h00);
    pk(2'h1, 1, 1, 1, 1, STL, HS);
    rd(CNF, 8'hac);
    chk(cnf_o, 8'hac);
    rd(STAT, 8'h03);
    chk({7'h00, irq_o}, 8'h01);
    wr(STAT, 8'h02);
    rd(STAT, 8'h01);
    chk({7'h00, irq_o}, 8'h00);
    wr(STAT, 8'h07);
    wr(CNF, 8'ha0);
    pk(2'h1, 1, 1, 0, 1, ACK_X, ALL);
    rd(STAT, 8'h00);
    $display("test overrun and interrupt done");
    results();
  end
endmodule
`default_nettype wire
